/* File: logic/uawk_top.sv */
// port interrupt qualification, address detect and receive-pin wake-up
// assumes CLK_I runs while the port clock is gated; receiver on same clock
`timescale 1ns/100ps
module uawk_top (
    input  wire logic                  CLK_I,
    input  wire logic                  RESET_I,
    input  wire logic                  CE_I,
    input  wire logic                  PSEL_I,
    input  wire logic                  PENABLE_I,
    input  wire logic                  PWRITE_I,
    input  wire logic [7:0]            PADDR_I,
    input  wire logic [31:0]           PWDATA_I,
    output logic      [31:0]           PRDATA_O,
    output logic                       PREADY_O,
    output logic                       PSLVERR_O,
    input  wire logic                  PORT_CLK_ON_I,
    input  wire logic                  RX_PIN_I,
    input  wire uawk_pkg::uawk_rxword_s RX_WORD_I,
    input  wire uawk_pkg::uawk_txstat_s TX_STAT_I,
    output logic                       TX_PAUSE_O,
    output logic                       RX_PAUSE_O,
    output logic                       WAKE_O,
    output logic                       IRQ_O
);
    import uawk_pkg::*;

    // address flag is the last data bit of the selected word length
    function automatic logic top_bit(input logic [8:0] w,
                                     input logic nine);
        top_bit = nine ? w[8] : w[7];
    endfunction

    // registers sit in the low bits; upper read bits stay zero
    function automatic logic [31:0] pad(input logic [8:0] v);
        pad = {23'h000000, v};
    endfunction

    // register state
    logic [CTRL_W-1:0] ctrl;
    logic [2:0]        irqen;
    logic [8:0]        rx_data;
    logic              avail;
    logic              ovr;
    logic              stat_armed;
    logic [IRQ_W-1:0]  istat;
    logic [IRQ_W-1:0]  imask;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
    logic              txe_q;
    logic              txi_q;

    logic [CTRL_W-1:0] next_ctrl;
    logic [2:0]        next_irqen;
    logic [8:0]        next_rx_data;
    logic              next_avail;
    logic              next_ovr;
    logic              next_stat_armed;
    logic [IRQ_W-1:0]  next_istat;
    logic [IRQ_W-1:0]  next_imask;
    logic [31:0]       next_prdata;
    logic              next_pready;
    logic              next_pslverr;
    logic              next_irq;

    // wake state
    logic              rx_s1;
    logic              rx_s2;
    logic              rx_s3;
    uawk_wake_e        wk;
    logic              wake_hit;
    logic [CNT_W-1:0]  settle;
    logic              wake_o;
    logic              pause;
    logic              wake_evt;

    uawk_wake_e        next_wk;
    logic              next_wake_hit;
    logic [CNT_W-1:0]  next_settle;
    logic              next_wake_o;
    logic              next_pause;
    logic              next_wake_evt;

    // decode
    logic              setup;
    logic              done;
    logic              mapped;
    logic              wr;
    logic              rd;
    logic              accept;
    logic              fall;
    logic              wake_ok;
    logic [31:0]       rmux;
    logic [IRQ_W-1:0]  evt;

    always_comb begin
        setup  = PSEL_I & ~PENABLE_I;
        done   = PSEL_I & PENABLE_I & pready;
        mapped = (PADDR_I == OFS_CTRL)   | (PADDR_I == OFS_IRQEN) |
                 (PADDR_I == OFS_STATUS) | (PADDR_I == OFS_DATA)  |
                 (PADDR_I == OFS_ISTAT)  | (PADDR_I == OFS_IMASK);
        wr     = done & PWRITE_I & mapped;
        rd     = done & ~PWRITE_I & mapped;
        case (PADDR_I)
            OFS_CTRL:   rmux = pad(ctrl);
            OFS_IRQEN:  rmux = pad({6'h00, irqen});
            OFS_STATUS: rmux = pad({5'h00, TX_STAT_I.idle,
                                    TX_STAT_I.empty, ovr, avail});
            OFS_DATA:   rmux = pad(rx_data);
            OFS_ISTAT:  rmux = pad({4'h0, istat});
            OFS_IMASK:  rmux = pad({4'h0, imask});
            default:    rmux = 32'h00000000;
        endcase
        // words are dropped while the port is paused or settling
        accept = RX_WORD_I.valid & ctrl[C_PORT_EN] & ctrl[C_RECV_EN] &
                 PORT_CLK_ON_I & (wk == WK_RUN);
        evt = '0;
        evt[I_RX] = accept & ctrl[C_RXIRQ_EN] &
                    (~ctrl[C_ADDR_EN] |
                     top_bit(RX_WORD_I.data, ctrl[C_NINE]));
        evt[I_OVR] = accept & avail & ctrl[C_RXIRQ_EN];
        // transmitter events fire on the rising level, not while it stands
        evt[I_TXE] = TX_STAT_I.empty & ~txe_q & ctrl[C_TXE_EN];
        evt[I_TXI] = TX_STAT_I.idle & ~txi_q & ctrl[C_TXI_EN];
        evt[I_WAKE] = wake_evt;
    end

    // register file and interrupt gating
    always_comb begin
        next_ctrl       = ctrl;
        next_irqen      = irqen;
        next_imask      = imask;
        next_rx_data    = rx_data;
        next_avail      = avail;
        next_ovr        = ovr;
        next_stat_armed = stat_armed;
        next_istat      = istat;
        // ready answers in the first access cycle, never a wait state
        next_pready     = setup;
        next_pslverr    = setup & ~mapped;
        next_prdata     = setup ? rmux : prdata;
        if (wr && PADDR_I == OFS_CTRL) begin
            next_ctrl = PWDATA_I[CTRL_W-1:0];
        end
        if (wr && PADDR_I == OFS_IRQEN) begin
            next_irqen = PWDATA_I[2:0];
        end
        if (wr && PADDR_I == OFS_IMASK) begin
            next_imask = PWDATA_I[IRQ_W-1:0];
        end
        if (wr && PADDR_I == OFS_ISTAT) begin
            next_istat = istat & ~PWDATA_I[IRQ_W-1:0];
        end
        // status flags ignore writes; a data read clears avail, a status read then a data read clears ovr
        if (rd && PADDR_I == OFS_STATUS) begin
            next_stat_armed = 1'b1;
        end
        if (rd && PADDR_I == OFS_DATA) begin
            next_avail = 1'b0;
            if (stat_armed) begin
                next_ovr        = 1'b0;
                next_stat_armed = 1'b0;
            end
        end
        // arriving word wins over a clearing read in the same cycle
        if (accept) begin
            if (avail) begin
                next_ovr = 1'b1; // holding word kept, newest lost
            end else begin
                next_rx_data = RX_WORD_I.data;
            end
            next_avail = 1'b1;
        end
        // a new event beats a one written to clear it in the same cycle
        next_istat = next_istat | evt;
        // level request; next values so a write shows in the same cycle as the register
        next_irq = (|(next_istat & next_imask)) & next_irqen[E_PORT] &
                   next_irqen[E_MF] & next_irqen[E_GLB];
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            ctrl       <= CTRL_RST;
            irqen      <= IRQEN_RST;
            imask      <= IMASK_RST;
            rx_data    <= 9'h000;
            avail      <= 1'b0;
            ovr        <= 1'b0;
            stat_armed <= 1'b0;
            istat      <= IRQ_RST;
            prdata     <= 32'h00000000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            irq        <= 1'b0;
            txe_q      <= 1'b0;
            txi_q      <= 1'b0;
        end else if (CE_I) begin
            // nothing here reacts to the port clock going off
            ctrl       <= next_ctrl;
            irqen      <= next_irqen;
            imask      <= next_imask;
            rx_data    <= next_rx_data;
            avail      <= next_avail;
            ovr        <= next_ovr;
            stat_armed <= next_stat_armed;
            istat      <= next_istat;
            prdata     <= next_prdata;
            pready     <= next_pready;
            pslverr    <= next_pslverr;
            irq        <= next_irq;
            txe_q      <= TX_STAT_I.empty;
            txi_q      <= TX_STAT_I.idle;
        end
    end

    // wake-up: the pin is sampled on CLK_I, which keeps running while the
    // port clock is gated, so the edge is seen without the port clock
    always_comb begin
        fall    = rx_s3 & ~rx_s2;
        wake_ok = ctrl[C_WAKE_EN] & ctrl[C_PORT_EN] & ctrl[C_RECV_EN] &
                  ctrl[C_RXIRQ_EN];
        next_wk       = wk;
        next_wake_hit = wake_hit;
        next_settle   = settle;
        next_wake_o   = 1'b0;
        next_wake_evt = 1'b0;
        next_pause    = ~PORT_CLK_ON_I;
        case (wk)
            WK_RUN: begin
                if (!PORT_CLK_ON_I) begin
                    next_wk       = WK_ASLEEP;
                    // forget a wake seen in an earlier sleep
                    next_wake_hit = 1'b0;
                end
            end
            WK_ASLEEP: begin
                // keep both directions held until settling is over
                next_pause = 1'b1;
                if (fall && wake_ok && !wake_hit) begin
                    next_wake_o   = 1'b1;
                    next_wake_hit = 1'b1;
                end
                if (PORT_CLK_ON_I) begin
                    next_wk     = WK_SETTLE;
                    // each return restarts the full settling count
                    next_settle = CNT_RST;
                end
            end
            WK_SETTLE: begin
                next_pause = 1'b1;
                if (!PORT_CLK_ON_I) begin
                    next_wk = WK_ASLEEP;
                end else if (settle == CNT_W'(SETTLE_CYC - 1)) begin
                    next_wk       = WK_RUN;
                    next_wake_evt = wake_hit;
                    next_wake_hit = 1'b0;
                end else begin
                    next_settle = settle + 1'b1;
                end
            end
            default: begin
                next_wk = WK_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            rx_s1    <= 1'b1;
            rx_s2    <= 1'b1;
            rx_s3    <= 1'b1;
            wk       <= WK_RUN;
            wake_hit <= 1'b0;
            settle   <= CNT_RST;
            wake_o   <= 1'b0;
            pause    <= 1'b0;
            wake_evt <= 1'b0;
        end else if (CE_I) begin
            // rx_s1 and rx_s2 synchronise the pin; rx_s3 gives the edge
            rx_s1    <= RX_PIN_I;
            rx_s2    <= rx_s1;
            rx_s3    <= rx_s2;
            wk       <= next_wk;
            wake_hit <= next_wake_hit;
            settle   <= next_settle;
            wake_o   <= next_wake_o;
            pause    <= next_pause;
            wake_evt <= next_wake_evt;
        end
    end

    // every output comes straight from a flip-flop
    assign PRDATA_O   = prdata;
    assign PREADY_O   = pready;
    assign PSLVERR_O  = pslverr;
    assign TX_PAUSE_O = pause;
    assign RX_PAUSE_O = pause;
    assign WAKE_O     = wake_o;
    assign IRQ_O      = irq;
endmodule

/* File: logic/uawk_pkg.sv */
// constants and carrier types for the port address-detect and wake block
// assumes an APB master on the system clock and a receiver on the same clock
package uawk_pkg;
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_IRQEN  = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_DATA   = 8'h0C;
    localparam logic [7:0] OFS_ISTAT  = 8'h10;
    localparam logic [7:0] OFS_IMASK  = 8'h14;
    // port_ctrl2_reg bit positions
    localparam int C_PORT_EN  = 0;
    localparam int C_RECV_EN  = 1;
    localparam int C_RXIRQ_EN = 2;
    localparam int C_WAKE_EN  = 3;
    localparam int C_ADDR_EN  = 4;
    localparam int C_NINE     = 5;
    localparam int C_PARITY   = 6;
    localparam int C_TXE_EN   = 7;
    localparam int C_TXI_EN   = 8;
    localparam int CTRL_W     = 9;
    localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
    // cpu interrupt enables
    localparam int E_PORT = 0;
    localparam int E_MF   = 1;
    localparam int E_GLB  = 2;
    localparam logic [2:0] IRQEN_RST = 3'h0;
    // port_status_reg bit positions
    localparam int S_AVAIL = 0;
    localparam int S_OVR   = 1;
    localparam int S_TXE   = 2;
    localparam int S_TXI   = 3;
    // sticky interrupt status bits
    localparam int I_RX   = 0;
    localparam int I_OVR  = 1;
    localparam int I_TXE  = 2;
    localparam int I_TXI  = 3;
    localparam int I_WAKE = 4;
    localparam int IRQ_W  = 5;
    localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;
    localparam logic [IRQ_W-1:0] IMASK_RST = 5'h00;
    // settling time after the port clock restarts
    localparam int CLK_MHZ    = 10;
    localparam int SETTLE_NS  = 2000;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W      = 12;
    localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
    typedef struct packed {
        logic       valid;
        logic [8:0] data;
    } uawk_rxword_s;
    typedef struct packed {
        logic empty;
        logic idle;
    } uawk_txstat_s;
    typedef enum logic [1:0] {WK_RUN, WK_ASLEEP, WK_SETTLE} uawk_wake_e;
endpackage

/* File: testbench/uawk_rxsrc.sv */
// far-side model: receive pin and words handed over by the receiver
// assumes one-cycle request pulses from the bench
`timescale 1ns/100ps
module uawk_rxsrc
    import uawk_pkg::*;
(
    input  wire logic           clk_i,
    input  wire logic           fall_req_i,
    input  wire logic           send_req_i,
    input  wire logic [8:0]     word_i,
    output logic                rx_pin_o,
    output uawk_pkg::uawk_rxword_s rx_word_o
);
    logic [2:0] low_cnt = 3'h0;
    // idle line is pulled high; a start bit holds it low four cycles
    assign rx_pin_o = (low_cnt == 3'h0);
    always_ff @(posedge clk_i) begin
        low_cnt <= fall_req_i ? 3'h4 : low_cnt - {2'h0, low_cnt != 3'h0};
        rx_word_o.valid <= send_req_i;
        // no word on offer: data toggles so nothing stale looks valid
        rx_word_o.data <= send_req_i ? word_i : ~rx_word_o.data;
    end
endmodule

/* File: testbench/uawk_chk.sv */
// port checker for the address-detect and wake block
// assumes enables change only through completed apb writes
`timescale 1ns/100ps
module uawk_chk
    import uawk_pkg::*;
(
    input wire logic         CLK_I,
    input wire logic         RESET_I,
    input wire logic         PSEL_I,
    input wire logic         PENABLE_I,
    input wire logic         PWRITE_I,
    input wire logic [7:0]   PADDR_I,
    input wire logic [31:0]  PWDATA_I,
    input wire logic         PREADY_O,
    input wire logic         PSLVERR_O,
    input wire logic         PORT_CLK_ON_I,
    input wire uawk_pkg::uawk_rxword_s RX_WORD_I,
    input wire logic         TX_PAUSE_O,
    input wire logic         RX_PAUSE_O,
    input wire logic         WAKE_O,
    input wire logic         IRQ_O
);
    logic [CTRL_W-1:0] ctrl;
    logic [2:0]        ien;
    logic [IRQ_W-1:0]  msk;
    logic              wr;
    logic              tbit;
    logic              take;
    assign wr = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & ~PSLVERR_O;
    assign tbit = ctrl[C_NINE] ? RX_WORD_I.data[8] : RX_WORD_I.data[7];
    assign take = RX_WORD_I.valid & PORT_CLK_ON_I & ~RX_PAUSE_O
                & ctrl[C_PORT_EN] & ctrl[C_RECV_EN];
    // shadow of the enables, so assertions can see the gating
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            ctrl <= CTRL_RST;
            ien  <= IRQEN_RST;
            msk  <= IMASK_RST;
        end else if (wr) begin
            case (PADDR_I)
                OFS_CTRL:  ctrl <= PWDATA_I[CTRL_W-1:0];
                OFS_IRQEN: ien <= PWDATA_I[2:0];
                OFS_IMASK: msk <= PWDATA_I[IRQ_W-1:0];
                default:   ctrl <= ctrl;
            endcase
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    sequence s_restart;
        $rose(PORT_CLK_ON_I);
    endsequence
    a_ready_once: assert property (PSEL_I && !PENABLE_I |=>
        PREADY_O ##1 !PREADY_O) else $error("bad apb answer");
    a_irq_gated: assert property (IRQ_O |-> &ien)
        else $error("irq without enables");
    a_data_irq: assert property (take && (!ctrl[C_ADDR_EN] || tbit)
        && ctrl[C_RXIRQ_EN] && &ien && msk[I_RX] |=> IRQ_O)
        else $error("data irq missing");
    a_addr_block: assert property (take && ctrl[C_ADDR_EN] && !tbit
        && !(|msk[IRQ_W-1:1]) && !IRQ_O && !wr |=> !IRQ_O)
        else $error("data word raised irq");
    a_wake_cond: assert property (WAKE_O |-> RX_PAUSE_O
        && &ctrl[C_WAKE_EN:C_PORT_EN]) else $error("wake not allowed");
    a_wake_pulse: assert property (WAKE_O |=> !WAKE_O)
        else $error("wake pulse too long");
    a_sleep_pause: assert property ($fell(PORT_CLK_ON_I) |=>
        TX_PAUSE_O && RX_PAUSE_O) else $error("no pause when off");
    a_settle_hold: assert property (s_restart |=>
        (TX_PAUSE_O && RX_PAUSE_O)[*8]) else $error("settle too short");
    a_settle_end: assert property (s_restart |-> ##[1:30] !RX_PAUSE_O)
        else $error("settle never ends");
    a_wake_late: assert property (s_restart ##1 !IRQ_O |=>
        !IRQ_O[*8]) else $error("irq during settle");
endmodule
bind uawk_top uawk_chk u_chk (
    .CLK_I(CLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .PORT_CLK_ON_I(PORT_CLK_ON_I), .RX_WORD_I(RX_WORD_I),
    .TX_PAUSE_O(TX_PAUSE_O), .RX_PAUSE_O(RX_PAUSE_O),
    .WAKE_O(WAKE_O), .IRQ_O(IRQ_O)
);

/* File: testbench/tb.sv */
// bench: apb tasks and call sequences for address detect and wake
// assumes uawk_rxsrc as the far side and the bound port checker
`timescale 1ns/100ps
module tb;
    import uawk_pkg::*;
    logic        clk      = 1'h0;
    logic        rst      = 1'h1;
    logic        psel     = 1'h0;
    logic        pen      = 1'h0;
    logic        pwr      = 1'h0;
    logic        clk_on   = 1'h1;
    logic        fall_req = 1'h0;
    logic        send_req = 1'h0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0;
    logic [8:0]  word     = 9'h000;
    logic [8:0]  w9;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, slv, tx_pause, rx_pause, wake, irq;
    logic        rx_pin, exp;
    uawk_rxword_s rx_word;
    uawk_txstat_s tx_stat = '0;
    int          err_count = 0;
    int          compares  = 0;
    always #50 clk = ~clk;
    uawk_rxsrc u_src (.clk_i(clk), .fall_req_i(fall_req),
        .send_req_i(send_req), .word_i(word), .rx_pin_o(rx_pin),
        .rx_word_o(rx_word));
    uawk_top uut (.CLK_I(clk), .RESET_I(rst), .CE_I(1'h1), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .PORT_CLK_ON_I(clk_on), .RX_PIN_I(rx_pin),
        .RX_WORD_I(rx_word), .TX_STAT_I(tx_stat), .TX_PAUSE_O(tx_pause),
        .RX_PAUSE_O(rx_pause), .WAKE_O(wake), .IRQ_O(irq));
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] ex,
                       input string nm);
        compares++;
        if (seen !== ex) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel   <= 1'h1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rd  = prdata;
        slv = pslverr;
        psel <= 1'h0;
        pen  <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] ex,
                       input string nm);
        bus(1'h0, a, 32'h0);
        chk(rd, ex, nm);
    endtask
    task automatic send(input logic [8:0] w);
        word     <= w;
        send_req <= 1'h1;
        @(posedge clk);
        send_req <= 1'h0;
        repeat (2) @(posedge clk);
    endtask
    task automatic sleep_fall();
        int n;
        n = 0;
        clk_on <= 1'h0;
        repeat (2) @(posedge clk);
        chk(tx_pause, 1, "tx pause");
        chk(rx_pause, 1, "rx pause");
        fall_req <= 1'h1;
        @(posedge clk);
        fall_req <= 1'h0;
        do begin
            @(posedge clk);
            n++;
        end while (wake !== 1'h1 && n < 20);
        chk(wake, 1, "wake");
        chk(irq, 0, "asleep irq");
        clk_on <= 1'h1;
        @(posedge clk);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        rdc(OFS_CTRL, 32'h0, "ctrl reset");
        rdc(OFS_ISTAT, 32'h0, "istat reset");
        bus(1'h0, 8'h18, 32'h0);
        chk(slv, 1, "unmapped");
        bus(1'h1, OFS_IRQEN, 32'h7);
        bus(1'h1, OFS_IMASK, 32'h1);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            // the bit not under test is opposite, so a wrong pick shows
            w9 = i[1] ? {i[0], ~i[0], 7'h00} : {~i[0], i[0], 7'h00};
            exp = !i[2] || i[0];
            bus(1'h1, OFS_CTRL, {26'h0, i[1], i[2], 4'h7});
            send(w9);
            chk(irq, exp, "irq");
            rdc(OFS_ISTAT, {31'h0, exp}, "istat");
            bus(1'h1, OFS_STATUS, 32'h0);
            rdc(OFS_STATUS, 32'h1, "avail");
            rdc(OFS_DATA, w9, "data");
            rdc(OFS_STATUS, 32'h0, "avail clear");
            bus(1'h1, OFS_ISTAT, 32'h1F);
        end
        bus(1'h1, OFS_IRQEN, 32'h3);
        send(9'h100);
        chk(irq, 0, "global off");
        bus(1'h1, OFS_IRQEN, 32'h7);
        chk(irq, 1, "global on");
        rdc(OFS_DATA, 32'h100, "data");
        bus(1'h1, OFS_ISTAT, 32'h1F);
        $display("test address detect done");
        bus(1'h1, OFS_CTRL, 32'h83);
        bus(1'h1, OFS_IMASK, 32'hC);
        tx_stat <= '{empty: 1'h1, idle: 1'h1};
        repeat (2) @(posedge clk);
        chk(irq, 1, "tx irq");
        rdc(OFS_ISTAT, 32'h4, "tx istat");
        rdc(OFS_STATUS, 32'hC, "tx status");
        tx_stat <= '0;
        bus(1'h1, OFS_ISTAT, 32'h1F);
        $display("test transmitter done");
        bus(1'h1, OFS_CTRL, 32'hF);
        bus(1'h1, OFS_IMASK, 32'h10);
        sleep_fall();
        send(9'h055);
        chk(irq, 0, "settling");
        rdc(OFS_STATUS, 32'h0, "dropped");
        repeat (25) @(posedge clk);
        chk(irq, 1, "wake irq");
        rdc(OFS_ISTAT, 32'h10, "wake istat");
        rdc(OFS_CTRL, 32'hF, "ctrl kept");
        bus(1'h1, OFS_ISTAT, 32'h1F);
        bus(1'h1, OFS_IRQEN, 32'h3);
        sleep_fall();
        repeat (25) @(posedge clk);
        chk(irq, 0, "wake only");
        $display("test wake done");
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        finish_test();
    end
endmodule
